// File: rtl/rvl_pkg.sv
// Constants, field layout and types for the ring validation block
package rvl_pkg;

    // =========================================================
    // Timebase
    localparam int CLK_FREQ_KHZ = 125000;
    localparam int TICK_MS = 2;
    localparam int TICK_CYCLES = CLK_FREQ_KHZ * TICK_MS;

    // =========================================================
    // Time units, in ms and in 2 ms ticks
    localparam int DLY_UNIT_MS = 256;
    localparam int TO_UNIT_MS = 128;
    localparam int CONF_UNIT_MS = 128;
    localparam logic [10:0] DLY_UNIT_TICKS = 11'(DLY_UNIT_MS / TICK_MS);
    localparam logic [10:0] TO_UNIT_TICKS = 11'(TO_UNIT_MS / TICK_MS);
    localparam logic [10:0] CONF_UNIT_TICKS = 11'(CONF_UNIT_MS / TICK_MS);

    // =========================================================
    // Register offsets
    localparam logic [7:0] ADDR_CTRL1 = 8'h16;
    localparam logic [7:0] ADDR_CTRL2 = 8'h17;
    localparam logic [7:0] ADDR_CTRL3 = 8'h18;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h20;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h21;
    localparam logic [7:0] ADDR_RING_STAT = 8'h22;

    // =========================================================
    // Reset values
    localparam logic [7:0] CTRL1_RST = 8'h00;
    localparam logic [7:0] CTRL2_RST = 8'h2d;
    localparam logic [7:0] CTRL3_RST = 8'h19;
    localparam logic [2:0] IRQ_MASK_RST = 3'h0;

    // =========================================================
    // Field positions
    localparam int C1_DLY_LSB = 6;
    localparam int C1_RMX_LSB = 0;
    localparam int C2_DLY_HI = 7;
    localparam int C2_RTO_LSB = 3;
    localparam int C2_RCC_LSB = 0;
    localparam int C3_EN_POS = 7;
    localparam int C3_RAS_LSB = 0;
    localparam logic [7:0] CTRL3_WMASK = 8'hbf;

    // =========================================================
    // Interrupt bits
    localparam int IRQ_VALID = 0;
    localparam int IRQ_INVAL = 1;
    localparam int IRQ_END = 2;
    localparam int IRQ_W = 3;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_QUAL,
        ST_DELAY,
        ST_VALID
    } rvl_state_t;

    // Code times unit, in ticks
    function automatic logic [10:0] rvl_scale(input logic [3:0] code, input logic [10:0] unit);
        return 11'(unit * {7'h00, code});
    endfunction

endpackage

// File: rtl/rvl_tick_gen.sv
// Divider giving a one-cycle 2 ms tick enable
`timescale 1ns/1ps
module rvl_tick_gen #(
    parameter int TICK_CYCLES = rvl_pkg::TICK_CYCLES
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Tick out
    output logic tick
);

    logic [31:0] div_reg;

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            div_reg <= 32'h0;
            tick <= 1'b0;
        end else if (div_reg == 32'(TICK_CYCLES - 1)) begin
            div_reg <= 32'h0;
            tick <= 1'b1;
        end else begin
            div_reg <= div_reg + 32'h1;
            tick <= 1'b0;
        end
    end

endmodule // rvl_tick_gen

// File: rtl/rvl_evt_sync.sv
// Two-flop synchroniser with rising edge pulse for the ring event pin
`timescale 1ns/1ps
module rvl_evt_sync (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Pin in, pulse out
    input wire logic pin_in,
    output logic rise
);

    logic meta_reg;
    logic sync_reg;
    logic last_reg;

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            last_reg <= 1'b0;
        end else begin
            meta_reg <= pin_in;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
        end
    end

    assign rise = sync_reg & ~last_reg;

endmodule // rvl_evt_sync

// File: rtl/rvl_ring_validation.sv
// Ring validation: event spacing check, confirm, delay, end timeout
//
// Overview of operation
// R1 - Valid ring shown after delay select code times 256 ms, 0 ms for code zero.
// R2 - Each tip/ring event loads the qualification timer with assertion time; it counts down.
// R3 - On a later event, timer above upper frequency limit means too fast: invalidate.
// R4 - Assertion time minus limit is least event spacing, in 2 ms steps.
// R5 - Software should add one to the computed upper frequency limit.
// R6 - Ringing ends after timeout code times 128 ms without events; code zero invalid.
// R7 - Ring is valid only after staying in tolerance over the confirm interval.
// R8 - Control register two resets to 0x2d.
// R9 - A later event after the timer expired means too slow: invalidate.
// R10 - Validation runs only while the enable bit is set, in all power modes.
// R11 - End timeout clears valid indication and re-arms qualification.
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
module rvl_ring_validation #(
    parameter int TICK_CYCLES = rvl_pkg::TICK_CYCLES
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Line side
    input wire logic ring_thresh_evt,
    // Ring status
    output logic ring_valid,
    output logic ring_active,
    output logic irq
);

    // =========================================================
    // Declarations
    logic tick;
    logic evt_rise;
    logic evt;

    logic [7:0] ctrl1_reg;
    logic [7:0] ctrl2_reg;
    logic ring_validate_enable_reg;
    logic [5:0] ras_reg;
    logic [rvl_pkg::IRQ_W-1:0] irq_stat_reg;
    logic [rvl_pkg::IRQ_W-1:0] irq_stat_next;
    logic [rvl_pkg::IRQ_W-1:0] irq_mask_reg;
    logic [rvl_pkg::IRQ_W-1:0] irq_evt;

    rvl_pkg::rvl_state_t state_reg;
    rvl_pkg::rvl_state_t state_next;

    logic [5:0] qual_tmr_reg;
    logic [10:0] phase_cnt_reg;
    logic [10:0] end_cnt_reg;

    logic [2:0] ring_indicate_delay_sel;
    logic [5:0] ring_upper_freq_limit;
    logic [3:0] ring_end_timeout_sel;
    logic [2:0] ring_confirm_interval;

    logic [10:0] dly_limit;
    logic [10:0] end_limit;
    logic [10:0] conf_limit;

    logic too_high;
    logic too_low;
    logic bad_evt;
    logic end_hit;
    logic restart;
    logic in_eval;
    logic [3:0] end_code;

    // =========================================================
    // Register write select
    // Exact address match; writes to unmapped addresses fall through
    function automatic logic wr_sel(input logic wr, input logic [7:0] addr, input logic [7:0] target);
        return wr && (addr == target);
    endfunction

    // =========================================================
    // Timebase and event input
    rvl_tick_gen #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_tick (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .tick(tick)
    );

    rvl_evt_sync u_evt (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .pin_in(ring_thresh_evt),
        .rise(evt_rise)
    );

    // Edges seen while disabled are dropped, not queued
    assign evt = evt_rise & ring_validate_enable_reg; // [R10]

    // =========================================================
    // Field decode
    assign ring_indicate_delay_sel = {ctrl2_reg[rvl_pkg::C2_DLY_HI],
                                      ctrl1_reg[rvl_pkg::C1_DLY_LSB +: 2]};
    assign ring_upper_freq_limit = ctrl1_reg[rvl_pkg::C1_RMX_LSB +: 6];
    assign ring_end_timeout_sel = ctrl2_reg[rvl_pkg::C2_RTO_LSB +: 4];
    assign ring_confirm_interval = ctrl2_reg[rvl_pkg::C2_RCC_LSB +: 3];

    // Delay in 256 ms units
    assign dly_limit = rvl_pkg::rvl_scale({1'b0, ring_indicate_delay_sel},
                                          rvl_pkg::DLY_UNIT_TICKS); // [R1]

    // Invalid code zero runs as the shortest timeout
    assign end_code = (ring_end_timeout_sel == 4'h0) ? 4'h1 : ring_end_timeout_sel; // [R6]
    assign end_limit = rvl_pkg::rvl_scale(end_code, rvl_pkg::TO_UNIT_TICKS); // [R6]

    assign conf_limit = rvl_pkg::rvl_scale({1'b0, ring_confirm_interval} + 4'h1,
                                           rvl_pkg::CONF_UNIT_TICKS); // [R7]

    // =========================================================
    // Event spacing checks
    // Remaining time above the limit: events came too close
    assign too_high = qual_tmr_reg > ring_upper_freq_limit; // [R3] [R4]

    // Timer ran out: events came too far apart
    assign too_low = qual_tmr_reg == 6'h00; // [R9]

    // Any state but idle is an evaluation in progress
    assign in_eval = state_reg != rvl_pkg::ST_IDLE;

    assign bad_evt = evt && in_eval && (too_high || too_low); // [R3] [R9]

    assign end_hit = in_eval && (end_cnt_reg >= end_limit); // [R6]

    // Event that starts a fresh evaluation
    assign restart = evt && ((state_reg == rvl_pkg::ST_IDLE) || bad_evt || end_hit);

    // =========================================================
    // State machine
    always_comb begin
        state_next = state_reg;
        if (!ring_validate_enable_reg) begin
            state_next = rvl_pkg::ST_IDLE; // [R10]
        end else begin
            case (state_reg)
                rvl_pkg::ST_IDLE: begin
                    if (evt) begin
                        state_next = rvl_pkg::ST_QUAL;
                    end
                end
                rvl_pkg::ST_QUAL: begin
                    if (restart) begin
                        state_next = rvl_pkg::ST_QUAL; // [R3] [R9]
                    end else if (end_hit) begin
                        state_next = rvl_pkg::ST_IDLE; // [R11]
                    end else if (phase_cnt_reg >= conf_limit) begin
                        state_next = rvl_pkg::ST_DELAY; // [R7]
                    end
                end
                rvl_pkg::ST_DELAY: begin
                    if (restart) begin
                        state_next = rvl_pkg::ST_QUAL; // [R3] [R9]
                    end else if (end_hit) begin
                        state_next = rvl_pkg::ST_IDLE; // [R11]
                    end else if (phase_cnt_reg >= dly_limit) begin
                        state_next = rvl_pkg::ST_VALID; // [R1]
                    end
                end
                rvl_pkg::ST_VALID: begin
                    if (restart) begin
                        state_next = rvl_pkg::ST_QUAL; // [R3] [R9]
                    end else if (end_hit) begin
                        state_next = rvl_pkg::ST_IDLE; // [R11]
                    end
                end
                default: begin
                    state_next = rvl_pkg::ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= rvl_pkg::ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // =========================================================
    // Qualification timer
    // Holds at zero so the next event sees an expired timer
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            qual_tmr_reg <= 6'h00;
        end else if (evt) begin
            qual_tmr_reg <= ras_reg; // [R2]
        end else if (tick && qual_tmr_reg != 6'h00) begin
            qual_tmr_reg <= qual_tmr_reg - 6'h01; // [R2] [R4]
        end
    end

    // =========================================================
    // Confirm and delay phase counter
    // A restart throws away confirm and delay progress
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            phase_cnt_reg <= 11'h000;
        end else if (restart || state_next != state_reg) begin
            phase_cnt_reg <= 11'h000; // [R7]
        end else if (tick && phase_cnt_reg != 11'h7ff) begin
            phase_cnt_reg <= phase_cnt_reg + 11'h001;
        end
    end

    // =========================================================
    // Ringing end timer, time since last crossing
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            end_cnt_reg <= 11'h000;
        end else if (evt || state_reg == rvl_pkg::ST_IDLE) begin
            end_cnt_reg <= 11'h000; // [R6] [R11]
        end else if (tick && end_cnt_reg != 11'h7ff) begin
            end_cnt_reg <= end_cnt_reg + 11'h001; // [R6]
        end
    end

    // =========================================================
    // Status outputs
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ring_valid <= 1'b0;
            ring_active <= 1'b0;
        end else begin
            ring_valid <= state_next == rvl_pkg::ST_VALID; // [R1] [R11]
            ring_active <= state_next != rvl_pkg::ST_IDLE;
        end
    end

    // =========================================================
    // Control registers
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl1_reg <= rvl_pkg::CTRL1_RST;
        end else if (wr_sel(reg_wr, reg_addr, rvl_pkg::ADDR_CTRL1)) begin
            ctrl1_reg <= reg_wdata;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl2_reg <= rvl_pkg::CTRL2_RST; // [R8]
        end else if (wr_sel(reg_wr, reg_addr, rvl_pkg::ADDR_CTRL2)) begin
            ctrl2_reg <= reg_wdata;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ring_validate_enable_reg <= rvl_pkg::CTRL3_RST[rvl_pkg::C3_EN_POS];
            ras_reg <= rvl_pkg::CTRL3_RST[rvl_pkg::C3_RAS_LSB +: 6];
        end else if (wr_sel(reg_wr, reg_addr, rvl_pkg::ADDR_CTRL3)) begin
            ring_validate_enable_reg <= reg_wdata[rvl_pkg::C3_EN_POS]; // [R10]
            ras_reg <= reg_wdata[rvl_pkg::C3_RAS_LSB +: 6];
        end
    end

    // =========================================================
    // Interrupt status, mask and line
    assign irq_evt[rvl_pkg::IRQ_VALID] = (state_next == rvl_pkg::ST_VALID) &&
                                         (state_reg != rvl_pkg::ST_VALID);
    assign irq_evt[rvl_pkg::IRQ_INVAL] = bad_evt;
    assign irq_evt[rvl_pkg::IRQ_END] = end_hit;

    // Set wins over a same-cycle write-one clear
    always_comb begin
        irq_stat_next = irq_stat_reg;
        if (wr_sel(reg_wr, reg_addr, rvl_pkg::ADDR_IRQ_STAT)) begin
            irq_stat_next = irq_stat_reg & ~reg_wdata[rvl_pkg::IRQ_W-1:0];
        end
        irq_stat_next = irq_stat_next | irq_evt;
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq_stat_reg <= '0;
        end else begin
            irq_stat_reg <= irq_stat_next;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq_mask_reg <= rvl_pkg::IRQ_MASK_RST;
        end else if (wr_sel(reg_wr, reg_addr, rvl_pkg::ADDR_IRQ_MASK)) begin
            irq_mask_reg <= reg_wdata[rvl_pkg::IRQ_W-1:0];
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat_next & irq_mask_reg);
        end
    end

    // =========================================================
    // Read data, one cycle after the strobe
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                rvl_pkg::ADDR_CTRL1: begin
                    reg_rdata <= ctrl1_reg;
                end
                rvl_pkg::ADDR_CTRL2: begin
                    reg_rdata <= ctrl2_reg;
                end
                rvl_pkg::ADDR_CTRL3: begin
                    reg_rdata <= {ring_validate_enable_reg, 1'b0, ras_reg};
                end
                rvl_pkg::ADDR_IRQ_STAT: begin
                    reg_rdata <= {5'h00, irq_stat_reg};
                end
                rvl_pkg::ADDR_IRQ_MASK: begin
                    reg_rdata <= {5'h00, irq_mask_reg};
                end
                rvl_pkg::ADDR_RING_STAT: begin
                    reg_rdata <= {ring_valid, ring_active, qual_tmr_reg};
                end
                default: begin
                    reg_rdata <= 8'h00;
                end
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

endmodule // rvl_ring_validation

// File: dv/rvl_checker.sv
// Port-level assertions for the ring validation block
`timescale 1ns/1ps
module rvl_checker #(
    parameter int TICK_CYCLES = 4
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // Line and status
    input wire logic ring_thresh_evt,
    input wire logic ring_valid,
    input wire logic ring_active,
    input wire logic irq
);
    logic [7:0] c1_reg;
    logic [7:0] c2_reg;
    logic [7:0] mask_reg;
    logic en_reg;
    logic evt_d_reg;
    logic act_d_reg;
    int since_evt_reg;
    int since_act_reg;
    int to_lim;
    int val_min;

    // =========================================================
    // Shadow of the written configuration
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            c1_reg <= 8'h00;
            c2_reg <= 8'h2d;
            mask_reg <= 8'h00;
            en_reg <= 1'b0;
        end else if (reg_wr) begin
            if (reg_addr == 8'h16) c1_reg <= reg_wdata;
            if (reg_addr == 8'h17) c2_reg <= reg_wdata;
            if (reg_addr == 8'h21) mask_reg <= reg_wdata;
            if (reg_addr == 8'h18) en_reg <= reg_wdata[7];
        end
    end

    // =========================================================
    // Cycles since last pin edge and since evaluation start
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            evt_d_reg <= 1'b0;
            act_d_reg <= 1'b0;
            since_evt_reg <= 0;
            since_act_reg <= 0;
        end else begin
            evt_d_reg <= ring_thresh_evt;
            act_d_reg <= ring_active;
            since_evt_reg <= (ring_thresh_evt && !evt_d_reg) ? 0 : since_evt_reg + 1;
            since_act_reg <= (ring_active && !act_d_reg) ? 1 : since_act_reg + 1;
        end
    end

    // Timeout 64 ticks a code step, confirm 64 and delay 128 ticks a step, two ticks slack each
    always_comb begin
        to_lim = ((c2_reg[6:3] == 4'h0) ? 1 : int'(c2_reg[6:3])) * 64 + 2;
        to_lim = to_lim * TICK_CYCLES + 16;
        val_min = (int'(c2_reg[2:0]) + 1) * 64 + int'({c2_reg[7], c1_reg[7:6]}) * 128 - 2;
        val_min = val_min * TICK_CYCLES;
    end

    // =========================================================
    // Assertions
    rdata_idle_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !reg_rd |=> reg_rdata == 8'h00) else $error("read data not zero outside read");
    ctrl2_read_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        reg_rd && reg_addr == 8'h17 |=> reg_rdata == c2_reg) else $error("control two read mismatch");
    unmapped_read_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        reg_rd && !(reg_addr inside {8'h16, 8'h17, 8'h18, 8'h20, 8'h21, 8'h22}) |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    valid_in_eval_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        ring_valid |-> ring_active) else $error("valid ring outside evaluation");
    disabled_idle_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (!en_reg) [*3] |-> !ring_active) else $error("evaluation while disabled");
    start_on_event_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        $rose(ring_active) |-> since_evt_reg <= 6) else $error("evaluation began without event");
    end_timeout_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        ring_active |-> since_evt_reg <= to_lim) else $error("ringing not ended after timeout");
    valid_not_early_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        $rose(ring_valid) |-> since_act_reg >= val_min) else $error("valid ring shown too early");
    valid_after_qual_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        $rose(ring_valid) |-> $past(ring_active, 2)) else $error("valid ring without qualification");
    // Line follows a mask write one cycle late
    irq_masked_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        irq |-> $past(mask_reg[2:0]) != 3'h0) else $error("interrupt with all sources masked");
endmodule // rvl_checker

bind rvl_ring_validation rvl_checker #(.TICK_CYCLES(TICK_CYCLES)) i_chk (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ring_thresh_evt(ring_thresh_evt),
    .ring_valid(ring_valid), .ring_active(ring_active), .irq(irq));

// File: dv/rvl_line_model.sv
// Ring detector model giving threshold edges at a set spacing
`timescale 1ns/1ps
module rvl_line_model (
    // Clock
    ref_clk,
    // Control
    run,
    gap,
    // Detector output
    pin
);
    input wire logic ref_clk;
    input wire logic run;
    input wire logic [15:0] gap;
    output logic pin;
    logic [15:0] cnt;

    initial cnt = 16'h0000;
    initial pin = 1'b0;

    // Pin low between rings, four-cycle pulse each gap cycles
    always @(posedge ref_clk) begin
        if (!run) begin
            cnt <= 16'h0000;
            pin <= 1'b0;
        end else begin
            cnt <= (cnt == gap - 16'h0001) ? 16'h0000 : cnt + 16'h0001;
            pin <= (cnt < 16'h0004);
        end
    end
endmodule // rvl_line_model

// File: dv/rvl_ring_validation_test.sv
// Self-checking test of the ring validation block
`timescale 1ns/1ps
module rvl_ring_validation_test;
    localparam int TC = 4;
    logic ref_clk, sys_rst, reg_wr, reg_rd, run, ring_valid, ring_active, irq, pin;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
    logic [15:0] gap;
    int n_errors, checks_done, t, i, want;
    logic [2:0] dly_tab [4] = '{3'h0, 3'h1, 3'h2, 3'h7};
    logic [2:0] cnf_tab [4] = '{3'h0, 3'h1, 3'h0, 3'h0};
    logic [7:0] rst_addr [6] = '{8'h16, 8'h17, 8'h18, 8'h20, 8'h21, 8'h30};
    logic [7:0] rst_val [6] = '{8'h00, 8'h2d, 8'h19, 8'h00, 8'h00, 8'h00};

    rvl_ring_validation #(.TICK_CYCLES(TC)) i_dut (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ring_thresh_evt(pin),
        .ring_valid(ring_valid), .ring_active(ring_active), .irq(irq));
    rvl_line_model i_line (.ref_clk(ref_clk), .run(run), .gap(gap), .pin(pin));

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    // =========================================================
    // Access and compare tasks
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
    task automatic burst(input logic [15:0] g, input int n);
        gap <= g;
        run <= 1'b1;
        repeat (n) @(posedge ref_clk);
        run <= 1'b0;
    endtask
    task automatic inval(input logic [15:0] g);
        burst(g, 400);
        rd(8'h20, d);
        check(d & 8'h02, 8'h02);
        check({7'h00, ring_valid}, 8'h00);
        wr(8'h21, 8'h00);
        @(posedge ref_clk);
        #1 check({7'h00, irq}, 8'h00);
        wr(8'h21, 8'h07);
        @(posedge ref_clk);
        #1 check({7'h00, irq}, 8'h01);
        repeat (400) @(posedge ref_clk);
        wr(8'h20, 8'h07);
        rd(8'h20, d);
        check(d, 8'h00);
        check({7'h00, irq}, 8'h00);
        $display("Invalid ring test done");
    endtask
    task automatic test_done;
        $display("Checks %0d, errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // =========================================================
    // Test sequence
    initial begin
        sys_rst = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        run = 1'b0;
        gap = 16'd88;
        n_errors = 0;
        checks_done = 0;
        repeat (3) @(posedge ref_clk);
        sys_rst <= 1'b0;
        for (i = 0; i < 6; i++) begin
            rd(rst_addr[i], d);
            check(d, rst_val[i]);
        end
        wr(8'h18, 8'hff);
        rd(8'h18, d);
        check(d, 8'hbf);
        $display("Register test done");
        wr(8'h21, 8'h07);
        wr(8'h18, 8'h99); // Enable, assertion time 25 ticks
        wr(8'h16, 8'h05); // Upper limit, computed 4 plus one
        wr(8'h17, 8'h08); // Timeout 128 ms, shortest confirm
        inval(16'd40);
        inval(16'd120);
        for (i = 0; i < 4; i++) begin
            wr(8'h16, {dly_tab[i][1:0], 6'h05});
            wr(8'h17, {dly_tab[i][2], 4'h1, cnf_tab[i]});
            gap <= 16'd88;
            run <= 1'b1;
            t = 0;
            while (ring_active !== 1'b1 && t < 100) begin
                @(posedge ref_clk);
                t++;
            end
            t = 0;
            while (ring_valid !== 1'b1 && t < 6000) begin
                @(posedge ref_clk);
                t++;
            end
            want = (64 * (int'(cnf_tab[i]) + 1) + 128 * int'(dly_tab[i])) * TC;
            check({7'h00, (t >= want - 12 && t <= want + 12)}, 8'h01);
            rd(8'h22, d);
            check(d & 8'hc0, 8'hc0);
            check({7'h00, irq}, 8'h01);
            @(posedge ref_clk);
            run <= 1'b0;
            repeat (400) @(posedge ref_clk);
            check({6'h00, ring_valid, ring_active}, 8'h00);
            rd(8'h20, d);
            check(d & 8'h05, 8'h05);
            wr(8'h20, 8'h07);
            rd(8'h20, d);
            check(d, 8'h00);
            check({7'h00, irq}, 8'h00);
            $display("Valid ring test done");
        end
        wr(8'h18, 8'h19);
        burst(16'd88, 400);
        check({7'h00, ring_active}, 8'h00);
        rd(8'h20, d);
        check(d, 8'h00);
        $display("Disabled test done");
        test_done();
    end

    initial begin
        #(60000 * 8);
        n_errors++;
        $display("ERROR at %0t: watchdog expired", $time);
        test_done();
    end
endmodule // rvl_ring_validation_test
